// file: axi_lite_port.sv
`timescale 1ns/100ps
`default_nettype none
module axi_lite_port
   import crypto_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_err,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);

   logic aw_q, w_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   assign s_awready = !aw_q && !s_bvalid;
   assign s_wready = !w_q && !s_bvalid;
   assign s_arready = !s_rvalid;
   assign wr_en = aw_q && w_q && !s_bvalid;
   assign wr_addr = awaddr_q;
   assign wr_data = wdata_q;
   assign wr_strb = wstrb_q;
   assign rd_addr = s_araddr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_awaddr;
         end else if (wr_en) begin
            aw_q <= 1'b0;
         end
         if (s_wvalid && s_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_wdata;
            wstrb_q <= s_wstrb;
         end else if (wr_en) begin
            w_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_bvalid <= 1'b0;
         s_bresp <= RESP_OKAY;
      end else if (wr_en) begin
         s_bvalid <= 1'b1;
         s_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_rvalid <= 1'b1;
         s_rdata <= rd_data;
         s_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_rready) begin
         s_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// file: crypto_pkg.sv
package crypto_pkg;

   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned OTP_READ_NS = 100;
   localparam int unsigned OP_NS = 200;
   localparam int unsigned OTP_READ_CYCLES = (OTP_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OP_CYCLES = (OP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 8;

   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_CFG_PAGE = 8'h08;
   localparam logic [7:0] ADDR_PROG_DATA = 8'h0C;
   localparam logic [7:0] ADDR_OTP_READ = 8'h10;
   localparam logic [7:0] ADDR_TEXT_B = 8'h14;
   localparam logic [7:0] ADDR_TEXT_A = 8'h18;

   localparam int unsigned ST_BUSY = 7;
   localparam int unsigned ST_TXTA = 6;
   localparam int unsigned ST_ABORT = 5;
   localparam int unsigned ST_WRAP = 4;
   localparam int unsigned ST_MODE = 2;
   localparam int unsigned ST_KEY = 1;
   localparam int unsigned ST_PGM = 0;

   localparam int unsigned CT_GO = 0;
   localparam int unsigned CT_WR = 1;
   localparam int unsigned CT_ON = 2;
   localparam int unsigned CT_MD = 3;
   localparam int unsigned CT_KSRC_LO = 4;
   localparam int unsigned CT_PAGE_LO = 8;
   localparam int unsigned CT_CIPH_LO = 12;
   localparam int unsigned CT_KSIZE_LO = 14;
   localparam int unsigned CT_OP_LO = 16;

   localparam int unsigned CF_KTYPE_LO = 20;
   localparam int unsigned CF_SKEY = 19;
   localparam int unsigned CF_LSRC_LO = 11;
   localparam int unsigned CF_SOURCE_LOCK_BIT = 10;
   localparam int unsigned CF_LOCK_LO = 1;
   localparam int unsigned CF_SWDIS = 0;

   localparam logic [23:0] CFG_RESET = 24'h00_0000;
   localparam logic [3:0] KSRC_SW = 4'h0;
   localparam logic [3:0] KSRC_STORED1 = 4'h1;
   localparam logic [3:0] KSRC_STORED2 = 4'h2;
   localparam logic [3:0] LAST_PAGE = 4'h8;
   localparam logic [3:0] CFG_PAGE_NUM = 4'h0;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {CIPH_ECB, CIPH_CBC, CIPH_CFB, CIPH_CTR} cipher_mode_t;
   typedef enum logic [3:0] {OP_ENCRYPT, OP_DECRYPT, OP_SESSION_KEY, OP_KEY_WRAP} op_mode_t;

endpackage

// file: crypto_status_key_config.sv
`timescale 1ns/100ps
`default_nettype none
module crypto_status_key_config
   import crypto_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);

   logic wr_en, wr_err, rd_err;
   logic [7:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_strb;

   logic go_q, wr_start_q, on_q, md_q;
   logic [3:0] ksrc_q, page_q;
   logic [1:0] cipher_q, ksize_q;
   logic [3:0] op_q;
   logic [23:0] cfg_q, prog_q;
   logic [15:0] text_b_q;
   logic [31:0] text_a_q;
   logic [CNT_W-1:0] op_cnt_q, otp_cnt_q;
   logic otp_rd_q, abort_q, wrap_q;
   logic [3:0] key_source;
   logic mode_fail, key_fail, pgm_fail, otp_rd_req;
   logic ctrl_wr, status_wr, go_wr1, go_wr0, go_start, go_done, go_clear;
   logic op_busy, wrap_event, abort_event, wr_start_ok;
   logic text_a_wr, text_b_wr, prog_wr;
   logic [15:0] status_word;

   axi_lite_port u_port (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_bresp(s_bresp),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .s_araddr(s_araddr),
      .s_arvalid(s_arvalid),
      .s_arready(s_arready),
      .s_rdata(s_rdata),
      .s_rresp(s_rresp),
      .s_rvalid(s_rvalid),
      .s_rready(s_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_err(wr_err),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   key_source_decode u_ksrc (
      .source_lock_bit(cfg_q[CF_SOURCE_LOCK_BIT]),
      .locked_source_field(cfg_q[CF_LSRC_LO +: 8]),
      .key_source_select(ksrc_q),
      .key_source(key_source)
   );

   function automatic logic addr_known(input logic [7:0] a);
      return a == ADDR_STATUS || a == ADDR_CONTROL || a == ADDR_CFG_PAGE ||
         a == ADDR_PROG_DATA || a == ADDR_OTP_READ || a == ADDR_TEXT_B || a == ADDR_TEXT_A;
   endfunction

   // Byte-lane merge, used by the text and program data registers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic mode_bad(input logic [3:0] op, input logic [1:0] ciph);
      logic bad;
      bad = op > OP_KEY_WRAP;
      if ((op == OP_SESSION_KEY || op == OP_KEY_WRAP) && ciph != CIPH_ECB) begin
         bad = 1'b1;
      end
      return bad;
   endfunction

   assign wr_err = !addr_known(wr_addr);
   assign rd_err = !addr_known(rd_addr);
   assign ctrl_wr = wr_en && wr_addr == ADDR_CONTROL;
   assign status_wr = wr_en && wr_addr == ADDR_STATUS && wr_strb[0];
   assign otp_rd_req = wr_en && wr_addr == ADDR_OTP_READ;
   // Text writes are dropped while busy rather than stalled
   assign text_a_wr = wr_en && wr_addr == ADDR_TEXT_A && !op_busy;
   assign text_b_wr = wr_en && wr_addr == ADDR_TEXT_B && !op_busy;
   assign prog_wr = wr_en && wr_addr == ADDR_PROG_DATA;

   // Checks are pure decode of configuration, so they hold with the engine off
   assign mode_fail = mode_bad(op_q, cipher_q);

   always_comb begin
      key_fail = 1'b0;
      if (cfg_q[CF_SWDIS] && key_source == KSRC_SW) begin
         key_fail = 1'b1;
      end
      // Stored keys one and two share one key type
      if ((key_source == KSRC_STORED1 || key_source == KSRC_STORED2) &&
          ksize_q != cfg_q[CF_KTYPE_LO +: 2]) begin
         key_fail = 1'b1;
      end
      if (cfg_q[CF_SKEY] && key_source == KSRC_STORED1 && op_q != OP_KEY_WRAP) begin
         key_fail = 1'b1;
      end
   end

   always_comb begin
      // Pages past the last one count as reserved
      if (page_q > LAST_PAGE) begin
         pgm_fail = 1'b1;
      end else begin
         pgm_fail = cfg_q[CF_LOCK_LO + 32'(page_q)];
      end
   end

   assign op_busy = go_q && on_q;
   assign go_wr1 = ctrl_wr && wr_strb[0] && wr_data[CT_GO];
   assign go_wr0 = ctrl_wr && wr_strb[0] && !wr_data[CT_GO];
   // Go is refused, not queued: software must read back to see it took
   // Checks see the settings held before this write, so turn the engine on first
   assign go_start = go_wr1 && !go_q && on_q && !md_q && !otp_rd_q && !wrap_q &&
      !abort_q && !mode_fail && !key_fail;
   assign go_done = go_q && op_cnt_q == CNT_W'(1);
   assign abort_event = go_q && go_wr0 && !go_done && !md_q;
   assign wrap_event = go_done && cipher_q == CIPH_CTR && text_b_q == 16'hFFFF;
   assign go_clear = go_q && (go_done || go_wr0 || md_q);
   assign wr_start_ok = ctrl_wr && wr_strb[0] && wr_data[CT_WR] && !otp_rd_q &&
      !mode_fail && !key_fail && !pgm_fail;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         on_q <= 1'b0;
         md_q <= 1'b0;
         ksrc_q <= 4'h0;
         page_q <= 4'h0;
         cipher_q <= CIPH_ECB;
         ksize_q <= 2'b00;
         op_q <= OP_ENCRYPT;
      end else if (ctrl_wr) begin
         if (wr_strb[0]) begin
            on_q <= wr_data[CT_ON];
            md_q <= wr_data[CT_MD];
            ksrc_q <= wr_data[CT_KSRC_LO +: 4];
         end
         if (wr_strb[1]) begin
            page_q <= wr_data[CT_PAGE_LO +: 4];
            cipher_q <= wr_data[CT_CIPH_LO +: 2];
            ksize_q <= wr_data[CT_KSIZE_LO +: 2];
         end
         if (wr_strb[2]) begin
            op_q <= wr_data[CT_OP_LO +: 4];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         go_q <= 1'b0;
         op_cnt_q <= '0;
      end else if (go_start) begin
         go_q <= 1'b1;
         op_cnt_q <= CNT_W'(OP_CYCLES);
      end else if (go_clear) begin
         go_q <= 1'b0;
         op_cnt_q <= '0;
      end else if (op_busy) begin
         op_cnt_q <= op_cnt_q - CNT_W'(1);
      end
   end

   // Text B counts one block per finished CTR operation
   // Wrap is the roll from all ones back to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         text_b_q <= 16'h0000;
      end else if (go_done && cipher_q == CIPH_CTR) begin
         text_b_q <= text_b_q + 16'h0001;
      end else if (text_b_wr) begin
         text_b_q <= 16'(merge({16'h0000, text_b_q}, wr_data, wr_strb));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         text_a_q <= 32'h0000_0000;
      end else if (text_a_wr) begin
         text_a_q <= merge(text_a_q, wr_data, wr_strb);
      end
   end

   // Event set wins over both clear sources
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         abort_q <= 1'b0;
      end else if (abort_event) begin
         abort_q <= 1'b1;
      end else if (go_clear || (status_wr && !wr_data[ST_ABORT])) begin
         abort_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wrap_q <= 1'b0;
      end else if (wrap_event) begin
         wrap_q <= 1'b1;
      end else if (go_clear || (status_wr && !wr_data[ST_WRAP])) begin
         wrap_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prog_q <= CFG_RESET;
      end else if (prog_wr) begin
         prog_q <= 24'(merge({8'h00, prog_q}, wr_data, wr_strb));
      end
   end

   // OTP cells only go from 0 to 1, so programming ORs in new bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= CFG_RESET;
      end else if (wr_start_q && page_q == CFG_PAGE_NUM && !pgm_fail) begin
         cfg_q <= cfg_q | prog_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_start_q <= 1'b0;
      end else begin
         wr_start_q <= wr_start_ok;
      end
   end

   // Reset starts a read, like the first read after power-on
   // A request during a read is ignored, not restarted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         otp_rd_q <= 1'b1;
         otp_cnt_q <= CNT_W'(OTP_READ_CYCLES);
      end else if (otp_rd_req && !otp_rd_q) begin
         otp_rd_q <= 1'b1;
         otp_cnt_q <= CNT_W'(OTP_READ_CYCLES);
      end else if (otp_rd_q) begin
         otp_cnt_q <= otp_cnt_q - CNT_W'(1);
         if (otp_cnt_q == CNT_W'(1)) begin
            otp_rd_q <= 1'b0;
         end
      end
   end

   // Disable masks the live flags; abort and wrap stay visible
   always_comb begin
      status_word = 16'h0000;
      status_word[ST_BUSY] = !md_q && (op_busy || otp_rd_q);
      status_word[ST_TXTA] = !md_q && op_busy;
      status_word[ST_ABORT] = abort_q;
      status_word[ST_WRAP] = wrap_q;
      status_word[ST_MODE] = !md_q && mode_fail;
      status_word[ST_KEY] = !md_q && (key_fail || otp_rd_q);
      status_word[ST_PGM] = !md_q && (pgm_fail || otp_rd_q);
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      unique case (rd_addr)
         ADDR_STATUS: rd_data = {16'h0000, status_word};
         ADDR_CONTROL: begin
            rd_data[CT_GO] = go_q;
            rd_data[CT_WR] = wr_start_q;
            rd_data[CT_ON] = on_q;
            rd_data[CT_MD] = md_q;
            rd_data[CT_KSRC_LO +: 4] = ksrc_q;
            rd_data[CT_PAGE_LO +: 4] = page_q;
            rd_data[CT_CIPH_LO +: 2] = cipher_q;
            rd_data[CT_KSIZE_LO +: 2] = ksize_q;
            rd_data[CT_OP_LO +: 4] = op_q;
         end
         ADDR_CFG_PAGE: rd_data = {8'h00, cfg_q};
         ADDR_PROG_DATA: rd_data = {8'h00, prog_q};
         ADDR_TEXT_B: rd_data = {16'h0000, text_b_q};
         ADDR_TEXT_A: rd_data = text_a_q;
         default: rd_data = 32'h0000_0000;
      endcase
   end

endmodule
`default_nettype wire

// file: crypto_status_key_config_props.sv
`timescale 1ns/100ps
`default_nettype none
module crypto_status_key_config_props
   import crypto_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   input wire logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   input wire logic s_wready,
   input wire logic [1:0] s_bresp,
   input wire logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic [31:0] s_rdata,
   input wire logic [1:0] s_rresp,
   input wire logic s_rvalid,
   input wire logic s_rready
);
   logic [7:0] age_q;
   logic status_rd_q;
   wire ar_hs = s_arvalid && s_arready;
   wire bad_ar = s_araddr > ADDR_TEXT_A || s_araddr[1:0] != 2'b00;

   // Saturates so a long run never reopens the start-up window
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         age_q <= 8'h00;
      end else if (age_q != 8'hff) begin
         age_q <= age_q + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (ar_hs) begin
         status_rd_q <= s_araddr == ADDR_STATUS;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_upper_zero: assert property (
      s_rvalid && status_rd_q |-> s_rdata[31:8] == 24'h00_0000 && !s_rdata[3])
      else $error("Status reserved bits not zero");
   a_otp_forced: assert property (
      ar_hs && s_araddr == ADDR_STATUS && age_q < 8'h10
      |=> s_rdata[7] && s_rdata[1] && s_rdata[0])
      else $error("Flags not forced during start-up read");
   a_resp_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("Write response dropped early");
   a_rdata_hold: assert property (
      s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata) && $stable(s_rresp))
      else $error("Read data dropped early");
   a_write_answer: assert property (
      s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid)
      else $error("Write response late");
   a_read_answer: assert property (ar_hs |=> s_rvalid)
      else $error("Read data late");
   a_unmapped_err: assert property (
      ar_hs && bad_ar |=> s_rresp == RESP_SLVERR && s_rdata == 32'h0000_0000)
      else $error("Unmapped read not refused");
   a_ar_blocked: assert property (s_rvalid |-> !s_arready)
      else $error("Read address taken while data pending");
   a_aw_blocked: assert property (s_bvalid |-> !s_awready && !s_wready)
      else $error("Write taken while response pending");
endmodule
`default_nettype wire

// file: key_source_decode.sv
`timescale 1ns/100ps
`default_nettype none
module key_source_decode
   import crypto_pkg::*;
(
   input wire logic source_lock_bit,
   input wire logic [7:0] locked_source_field,
   input wire logic [3:0] key_source_select,
   output logic [3:0] key_source
);

   function automatic logic [3:0] lock_prio(input logic [7:0] f);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < 7; i++) begin
         if (f[i]) begin
            r = 4'(i + 1);
         end
      end
      if (f[7]) begin
         r = 4'hF;
      end
      return r;
   endfunction

   always_comb begin
      if (source_lock_bit) begin
         key_source = lock_prio(locked_source_field);
      end else begin
         key_source = key_source_select;
      end
   end

endmodule
`default_nettype wire

// file: tb_crypto_status_key_config.sv
`timescale 1ns/100ps
`default_nettype none
module tb_crypto_status_key_config
   import crypto_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_awaddr = 8'h00;
   logic [7:0] s_araddr = 8'h00;
   logic [31:0] s_wdata = 32'h0000_0000;
   logic [3:0] s_wstrb = 4'hf;
   logic s_awvalid = 1'b0;
   logic s_wvalid = 1'b0;
   logic s_bready = 1'b0;
   logic s_arvalid = 1'b0;
   logic s_rready = 1'b0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp;
   logic [31:0] s_rdata;
   int n_errors = 0;
   int n_compared = 0;

   always #2.5 aclk = ~aclk;

   crypto_status_key_config crypto_status_key_config_i (
      .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
      .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Both channels offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end while (s_bvalid !== 1'b1);
      s_bready <= 1'b0;
      chk("write response", {29'h0, 1'b1, RESP_OKAY}, {29'h0, s_bvalid, s_bresp});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_arready) s_arvalid <= 1'b0;
      end while (s_rvalid !== 1'b1);
      s_rready <= 1'b0;
      chk("read response", {29'h0, 1'b1, er}, {29'h0, s_rvalid, s_rresp});
      chk($sformatf("read data at %h", a), exp, s_rdata);
   endtask

   task automatic st(input logic [31:0] e);
      rd(ADDR_STATUS, e, RESP_OKAY);
   endtask

   // Engine must be on before go; go low while running aborts
   task automatic ctl(input logic [31:0] d);
      wr(ADDR_CONTROL, d);
   endtask

   task automatic tally_and_finish;
      $display("Compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #100000;
      n_errors++;
      $display("Error watchdog expected finish seen hang");
      tally_and_finish;
   end

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      st(32'h0000_0083);
      repeat (OTP_READ_CYCLES + 5) @(posedge aclk);
      st(32'h0000_0000);
      rd(ADDR_CFG_PAGE, 32'h0000_0000, RESP_OKAY);
      rd(8'h1C, 32'h0000_0000, RESP_SLVERR);
      wr(ADDR_STATUS, 32'hFFFF_FFFF);
      st(32'h0000_0000);
      ctl(32'h0000_0004);
      ctl(32'h0000_0005);
      st(32'h0000_00C0);
      wr(ADDR_TEXT_A, 32'h1234_5678);
      rd(ADDR_TEXT_A, 32'h0000_0000, RESP_OKAY);
      repeat (OP_CYCLES) @(posedge aclk);
      st(32'h0000_0000);
      rd(ADDR_CONTROL, 32'h0000_0004, RESP_OKAY);
      ctl(32'h0000_0005);
      ctl(32'h0000_0004);
      st(32'h0000_0020);
      ctl(32'h0000_0005);
      st(32'h0000_0020);
      wr(ADDR_STATUS, 32'h0000_0030);
      st(32'h0000_0020);
      wr(ADDR_STATUS, 32'h0000_0000);
      st(32'h0000_0000);
      wr(ADDR_TEXT_B, 32'h0000_FFFF);
      ctl(32'h0000_3005);
      repeat (OP_CYCLES) @(posedge aclk);
      st(32'h0000_0010);
      rd(ADDR_TEXT_B, 32'h0000_0000, RESP_OKAY);
      ctl(32'h0000_3005);
      st(32'h0000_0010);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (OTP_READ_CYCLES + 5) @(posedge aclk);
      st(32'h0000_0000);
      ctl(32'h0002_1000);
      st(32'h0000_0004);
      wr(ADDR_PROG_DATA, 32'h0000_0001);
      ctl(32'h0002_1002);
      rd(ADDR_CFG_PAGE, 32'h0000_0000, RESP_OKAY);
      ctl(32'h0002_1008);
      st(32'h0000_0000);
      ctl(32'h0002_0000);
      st(32'h0000_0000);
      ctl(32'h0000_0022);
      rd(ADDR_CFG_PAGE, 32'h0000_0001, RESP_OKAY);
      ctl(32'h0000_0000);
      st(32'h0000_0002);
      ctl(32'h0000_4020);
      st(32'h0000_0002);
      wr(ADDR_PROG_DATA, 32'h0008_0000);
      ctl(32'h0000_4022);
      rd(ADDR_CFG_PAGE, 32'h0000_0001, RESP_OKAY);
      ctl(32'h0000_0020);
      st(32'h0000_0000);
      ctl(32'h0000_0022);
      ctl(32'h0000_0010);
      st(32'h0000_0002);
      ctl(32'h0003_0010);
      st(32'h0000_0000);
      wr(ADDR_PROG_DATA, 32'h0002_0400);
      ctl(32'h0000_0022);
      rd(ADDR_CFG_PAGE, 32'h000A_0401, RESP_OKAY);
      ctl(32'h0000_0000);
      st(32'h0000_0000);
      wr(ADDR_PROG_DATA, 32'h0000_0002);
      ctl(32'h0000_0022);
      st(32'h0000_0001);
      wr(ADDR_PROG_DATA, 32'h0010_0000);
      ctl(32'h0000_0022);
      rd(ADDR_CFG_PAGE, 32'h000A_0403, RESP_OKAY);
      ctl(32'h0000_0920);
      st(32'h0000_0001);
      ctl(32'h0000_0120);
      st(32'h0000_0000);
      wr(ADDR_OTP_READ, 32'h0000_0001);
      st(32'h0000_0083);
      tally_and_finish;
   end
endmodule

bind crypto_status_key_config crypto_status_key_config_props crypto_status_key_config_props_i (
   .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
   .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
   .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
   .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
   .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
`default_nettype wire
